// >>> bsh_map.vh
// Constants and field layout of the buffered serial handshake block
// What this block does
// RQ1 - Read-ack change loads next receive bytes
// RQ2 - Each new block inverts block-ready toggle
// RQ3 - Master toggles read-ack after reading data
// RQ4 - Read-ack after buffer exhausted clears inputs
// RQ5 - Send toggle change without copy change transmits whole buffer when idle
// RQ6 - Copy toggle change appends output data
// RQ7 - Master toggles copy bit to buffer data
// RQ8 - No read-ack, send or copy change: telegram passes directly when idle, not in command mode
// RQ9 - Master keeps data and copy change ordered
// RQ10 - Reset pattern AAh held over 20 ms
// RQ11 - Held pattern clears buffers and status
// RQ12 - Master refreshes image after reset
// RQ13 - Toggles act only in collective mode
// RQ14 - Change detected against registered control byte
// RQ15 - Length field reports following bytes 1..8, 0 when empty
// RQ16 - New-data toggle inverts per data set
// RQ17 - Collective mode holds receive data, flags pending
// RQ18 - Buffers hold up to one kilobyte
`ifndef BSH_MAP_VH
`define BSH_MAP_VH
`define BSH_RACK_BIT 0
`define BSH_SEND_BIT 2
`define BSH_COPY_BIT 3
`define BSH_RST_PATTERN 8'hAA
`define BSH_CLR_VALUE 8'h00
`define BSH_BUF_DEPTH 1024
`define BSH_PTR_W 11
`define BSH_PTR_ZERO 11'h000
`define BSH_BUF_FULL 11'h400
`define BSH_BLK_BYTES 8
`define BSH_CLK_MHZ 200
`define BSH_RST_HOLD_MS 20
`define BSH_RST_HOLD_CYC (`BSH_RST_HOLD_MS * 1000 * `BSH_CLK_MHZ + 1)
`endif

// >>> bsh_gateway.v
// Toggle-bit handshake and collective buffering of the serial gateway
`include "bsh_map.vh"
module bsh_gateway #(
  parameter RST_HOLD_CYC = `BSH_RST_HOLD_CYC
) (
  // Clock and reset
  input wire i_clk,
  input wire i_sys_rst,
  // Master output image, sampled once per fieldbus cycle
  input wire i_img_valid,
  input wire [7:0] i_ctrl0,
  input wire [7:0] i_ctrl1,
  input wire [63:0] i_out_data,
  input wire [7:0] i_out_len,
  input wire i_collective,
  // Serial side receive stream
  input wire i_rx_valid,
  input wire [7:0] i_rx_byte,
  // Serial side transmit stream
  input wire i_tx_ready,
  output reg o_tx_valid,
  output reg [7:0] o_tx_byte,
  // Master input image
  output reg [63:0] o_in_data,
  output reg [7:0] o_payload_length,
  output reg o_block_ready_toggle,
  output reg o_data_pending_flag,
  output reg o_new_data_toggle
);
  //------------------------------------------------------------
  // State and storage
  //------------------------------------------------------------
  localparam S_IDLE = 3'b001;
  localparam S_DIRECT = 3'b010;
  localparam S_FLUSH = 3'b100;
  reg [7:0] rx_mem [0:`BSH_BUF_DEPTH-1];
  reg [7:0] tx_mem [0:`BSH_BUF_DEPTH-1];
  reg [`BSH_PTR_W-1:0] rx_wr_reg, rx_rd_reg, tx_cnt_reg, tx_rd_reg;
  reg [7:0] ctrl1_reg;
  reg [2:0] state_reg;
  reg [63:0] dir_data_reg;
  reg [3:0] dir_len_reg, dir_idx_reg;
  reg [31:0] hold_cnt_reg;
  reg clear_pulse_reg;

  //------------------------------------------------------------
  // Event decode
  //------------------------------------------------------------
  wire [`BSH_PTR_W-1:0] rx_avail = rx_wr_reg - rx_rd_reg;
  wire [7:0] ctrl_chg = i_ctrl1 ^ ctrl1_reg; // [RQ14]
  wire take = i_img_valid & i_collective; // [RQ13]
  wire ev_rack = take & ctrl_chg[`BSH_RACK_BIT];
  wire ev_send = take & ctrl_chg[`BSH_SEND_BIT];
  wire ev_copy = take & ctrl_chg[`BSH_COPY_BIT];
  wire rst_pat = (i_ctrl0 == `BSH_RST_PATTERN) && (i_ctrl1 == `BSH_RST_PATTERN)
    && (i_out_data[7:0] == `BSH_RST_PATTERN) && (i_out_data[15:8] == `BSH_RST_PATTERN);
  wire [3:0] blk_n = (rx_avail > `BSH_BLK_BYTES) ? 4'h8 : rx_avail[3:0];
  wire [3:0] out_n = (i_out_len > `BSH_BLK_BYTES) ? 4'h8 : i_out_len[3:0];
  integer k;
  integer j;

  //------------------------------------------------------------
  // Reset pattern must stand longer than the hold time
  //------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      hold_cnt_reg <= 32'h0;
      clear_pulse_reg <= 1'b0;
    end
    else
    begin
      clear_pulse_reg <= 1'b0;
      if (!rst_pat)
        hold_cnt_reg <= 32'h0;
      else if (hold_cnt_reg < RST_HOLD_CYC)
      begin
        hold_cnt_reg <= hold_cnt_reg + 32'h1;
        if (hold_cnt_reg == RST_HOLD_CYC - 1)
          clear_pulse_reg <= 1'b1; // [RQ10]
      end
    end
  end

  //------------------------------------------------------------
  // Buffer memory writes
  //------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (clear_pulse_reg)
    begin
      if (i_rx_valid)
        rx_mem[10'h000] <= i_rx_byte; // [RQ17]
    end
    else if (i_rx_valid && rx_avail < `BSH_BUF_DEPTH)
      rx_mem[rx_wr_reg[9:0]] <= i_rx_byte; // [RQ17]
    if (ev_copy && !rst_pat)
      for (j = 0; j < `BSH_BLK_BYTES; j = j + 1)
        if (j < out_n && tx_cnt_reg + j < `BSH_BUF_DEPTH)
          tx_mem[tx_cnt_reg[9:0] + j[9:0]] <= i_out_data[8*j +: 8]; // [RQ6] [RQ18]
  end

  //------------------------------------------------------------
  // Pointers, handshake and transmit control
  //------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rx_wr_reg <= `BSH_PTR_ZERO;
      rx_rd_reg <= `BSH_PTR_ZERO;
      tx_cnt_reg <= `BSH_PTR_ZERO;
      tx_rd_reg <= `BSH_PTR_ZERO;
      ctrl1_reg <= 8'h00;
      state_reg <= S_IDLE;
      dir_data_reg <= 64'h0;
      dir_len_reg <= 4'h0;
      dir_idx_reg <= 4'h0;
      o_tx_valid <= 1'b0;
      o_tx_byte <= 8'h00;
      o_in_data <= 64'h0;
      o_payload_length <= 8'h00;
      o_block_ready_toggle <= 1'b0;
      o_data_pending_flag <= 1'b0;
      o_new_data_toggle <= 1'b0;
    end
    else if (clear_pulse_reg)
    begin
      // A byte landing with the clear starts the emptied buffer
      rx_wr_reg <= {{(`BSH_PTR_W-1){1'b0}}, i_rx_valid}; // [RQ11]
      rx_rd_reg <= `BSH_PTR_ZERO;
      tx_cnt_reg <= `BSH_PTR_ZERO;
      tx_rd_reg <= `BSH_PTR_ZERO;
      ctrl1_reg <= `BSH_CLR_VALUE;
      state_reg <= S_IDLE;
      o_tx_valid <= 1'b0;
      o_in_data <= 64'h0;
      o_payload_length <= `BSH_CLR_VALUE;
      o_block_ready_toggle <= 1'b0;
      o_data_pending_flag <= 1'b0;
      o_new_data_toggle <= 1'b0;
    end
    else
    begin
      if (i_rx_valid && rx_avail < `BSH_BUF_DEPTH)
        rx_wr_reg <= rx_wr_reg + 1'b1;
      o_data_pending_flag <= (rx_avail != 0); // [RQ17]
      // Pattern frames are not handshake events
      if (i_img_valid && !rst_pat)
        ctrl1_reg <= i_ctrl1;
      if (ev_rack && !rst_pat)
      begin
        if (rx_avail != 0)
        begin
          for (k = 0; k < `BSH_BLK_BYTES; k = k + 1)
            o_in_data[8*k +: 8] <= (k < blk_n) ?
              rx_mem[rx_rd_reg[9:0] + k[9:0]] : 8'h00; // [RQ1]
          rx_rd_reg <= rx_rd_reg + {7'h0, blk_n};
          o_payload_length <= {4'h0, blk_n}; // [RQ15]
          o_block_ready_toggle <= ~o_block_ready_toggle; // [RQ2]
          o_new_data_toggle <= ~o_new_data_toggle; // [RQ16]
        end
        else
        begin
          o_in_data <= 64'h0; // [RQ4]
          o_payload_length <= `BSH_CLR_VALUE;
        end
      end
      if (ev_copy && !rst_pat)
        tx_cnt_reg <= (tx_cnt_reg + {7'h0, out_n} > `BSH_BUF_DEPTH) ?
          `BSH_BUF_FULL : tx_cnt_reg + {7'h0, out_n};
      if (o_tx_valid && i_tx_ready)
        o_tx_valid <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          if (ev_send && !ev_copy && !rst_pat && tx_cnt_reg != 0)
          begin
            tx_rd_reg <= `BSH_PTR_ZERO;
            state_reg <= S_FLUSH; // [RQ5]
          end
          else if (i_img_valid && !ev_copy && !ev_send && !ev_rack && !rst_pat
            && i_out_len != 8'h00 && !i_ctrl0[0])
          begin
            dir_data_reg <= i_out_data; // [RQ8]
            dir_len_reg <= out_n;
            dir_idx_reg <= 4'h0;
            state_reg <= S_DIRECT;
          end
        end
        S_DIRECT:
        begin
          if (!o_tx_valid || i_tx_ready)
          begin
            if (dir_idx_reg == dir_len_reg)
              state_reg <= S_IDLE;
            else
            begin
              o_tx_valid <= 1'b1;
              o_tx_byte <= dir_data_reg[8*dir_idx_reg +: 8];
              dir_idx_reg <= dir_idx_reg + 4'h1;
            end
          end
        end
        S_FLUSH:
        begin
          if (!o_tx_valid || i_tx_ready)
          begin
            if (tx_rd_reg == tx_cnt_reg)
            begin
              tx_cnt_reg <= `BSH_PTR_ZERO;
              state_reg <= S_IDLE;
            end
            else
            begin
              o_tx_valid <= 1'b1;
              o_tx_byte <= tx_mem[tx_rd_reg[9:0]]; // [RQ5]
              tx_rd_reg <= tx_rd_reg + 1'b1;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // bsh_gateway

// >>> bsh_gateway_monitor.sv
// Checker of the gateway handshake outputs
module bsh_gateway_monitor (
  input wire i_clk, i_sys_rst, i_img_valid, i_collective, i_rx_valid, i_tx_ready,
  input wire [7:0] i_ctrl1,
  input wire [7:0] o_tx_byte, o_payload_length,
  input wire [63:0] o_in_data,
  input wire o_tx_valid, o_block_ready_toggle, o_data_pending_flag, o_new_data_toggle
);
  reg rack_reg;
  // Pattern images are refused, so they leave the copy alone
  always @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst) rack_reg <= 1'b0;
    else if (i_img_valid && i_ctrl1 != 8'hAA) rack_reg <= i_ctrl1[0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_load_block: assert property (
    i_img_valid && i_collective && i_ctrl1 != 8'hAA && i_ctrl1[0] != rack_reg
    && o_data_pending_flag |=> $changed(o_block_ready_toggle)) else $error("no block load");
  chk_newdata_pair: assert property (
    $changed(o_block_ready_toggle) |-> $changed(o_new_data_toggle))
    else $error("new data toggle stuck");
  chk_ready_cause: assert property (
    $changed(o_block_ready_toggle) |-> $past(i_img_valid) || !o_block_ready_toggle)
    else $error("block ready without image");
  chk_len_max: assert property (
    o_payload_length <= 8'h08) else $error("length too big");
  chk_len_empty: assert property (
    o_payload_length == 8'h00 |-> o_in_data == 64'h0) else $error("stale input data");
  chk_pend_src: assert property (
    $rose(o_data_pending_flag) |-> $past(i_rx_valid) || $past(i_rx_valid, 2))
    else $error("pending without rx");
  chk_tx_hold: assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte)) else $error("tx dropped");
  chk_mode_gate: assert property (
    !i_collective && i_img_valid && i_ctrl1 != 8'hAA |=> $stable(o_block_ready_toggle))
    else $error("toggle outside collective");
endmodule // bsh_gateway_monitor
bind bsh_gateway bsh_gateway_monitor chk_u (.*);

// >>> bsh_serial_dev.sv
// Serial end device model for the gateway
module bsh_serial_dev (
  input wire i_clk,
  input wire i_tx_valid,
  input wire [7:0] i_tx_byte,
  output logic o_tx_ready = 1'h1,
  output logic o_rx_valid = 1'h0,
  output logic [7:0] o_rx_byte = 8'hFF
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic stall = 1'h0;
  // Stalling alternates ready so a byte must be held
  always @(negedge i_clk) o_tx_ready <= stall ? ~o_tx_ready : 1'h1;
  always @(posedge i_clk) if (i_tx_valid && o_tx_ready) got.push_back(i_tx_byte);
  task automatic send(input logic [7:0] b);
    @(negedge i_clk);
    o_rx_valid = 1'h1;
    o_rx_byte = b;
    @(negedge i_clk);
    o_rx_valid = 1'h0;
    o_rx_byte = ~b;
  endtask
endmodule // bsh_serial_dev

// >>> bsh_gateway_tb_top.sv
// Testbench of the buffered serial handshake gateway
module bsh_gateway_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_sys_rst = 1, i_img_valid = 0, i_collective = 1;
  logic [7:0] i_ctrl0 = 0, i_ctrl1 = 0, i_out_len = 0, o_tx_byte, o_payload_length;
  logic [63:0] i_out_data = 0, o_in_data;
  wire i_rx_valid, i_tx_ready;
  wire [7:0] i_rx_byte;
  logic o_tx_valid, o_block_ready_toggle, o_data_pending_flag, o_new_data_toggle;
  int num_errors = 0, num_checks = 0;
  always #2.5 i_clk = ~i_clk;
  bsh_gateway #(.RST_HOLD_CYC(50)) dut_u (.*);
  bsh_serial_dev dev_u (.i_clk(i_clk), .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte),
    .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte));
  task automatic check(input string n, input logic [63:0] exp, got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic img(input logic [7:0] c1, input logic [63:0] d, input logic [7:0] n);
    @(negedge i_clk);
    i_img_valid = 1'h1;
    i_ctrl1 = c1;
    i_out_data = d;
    i_out_len = n;
    @(negedge i_clk);
    i_img_valid = 1'h0;
    @(negedge i_clk);
  endtask
  task automatic expect_tx(input logic [63:0] e, input int n);
    repeat (200) if (dev_u.got.size() < n) @(negedge i_clk);
    check("txn", n, dev_u.got.size());
    for (int k = 0; k < n; k++) check("txb", e[8*k+:8], dev_u.got[k]);
    dev_u.got.delete();
    repeat (3) @(negedge i_clk);
  endtask
  task automatic t_read;
    for (int k = 1; k <= 10; k++) dev_u.send(k[7:0]);
    check("pend", 1'h1, o_data_pending_flag);
    img(8'h01, 64'h0, 8'h00);
    check("blk1", 64'h0807060504030201, o_in_data);
    check("len1", 8'h08, o_payload_length);
    check("bready1", 1'h1, o_block_ready_toggle);
    check("newd1", 1'h1, o_new_data_toggle);
    img(8'h00, 64'h0, 8'h00);
    check("blk2", 64'h0A09, o_in_data);
    check("len2", 8'h02, o_payload_length);
    check("pend2", 1'h0, o_data_pending_flag);
    img(8'h01, 64'h0, 8'h00);
    check("clr", 64'h0, o_in_data);
  endtask
  task automatic t_send;
    dev_u.stall = 1'h1;
    img(8'h09, 64'hC3B2A1, 8'h03);
    img(8'h01, 64'hE5D4, 8'h02);
    check("held", 1'h0, dev_u.got.size());
    img(8'h05, 64'h0, 8'h00);
    expect_tx(64'hE5D4C3B2A1, 5);
    img(8'h05, 64'h0D0A, 8'h02);
    expect_tx(64'h0D0A, 2);
    // Command mode must keep a plain telegram off the serial side
    i_ctrl0 = 8'h01;
    img(8'h05, 64'h77, 8'h01);
    repeat (20) @(negedge i_clk);
    check("cmdtx", 64'h0, dev_u.got.size());
    i_ctrl0 = 8'h00;
  endtask
  task automatic t_gate;
    dev_u.send(8'h33);
    i_collective = 1'h0;
    img(8'h04, 64'h0, 8'h00);
    img(8'h05, 64'h0, 8'h00);
    check("gate", 1'h0, o_block_ready_toggle);
    i_collective = 1'h1;
  endtask
  task automatic t_reset;
    img(8'h04, 64'h0, 8'h00);
    check("blk3", 64'h33, o_in_data);
    dev_u.send(8'h44);
    @(negedge i_clk);
    i_ctrl0 = 8'hAA;
    i_ctrl1 = 8'hAA;
    i_out_data = 64'hAAAA;
    i_img_valid = 1'h1;
    repeat (60) @(negedge i_clk);
    i_img_valid = 1'h0;
    check("rbready", 1'h0, o_block_ready_toggle);
    check("rnewd", 1'h0, o_new_data_toggle);
    check("rpend", 1'h0, o_data_pending_flag);
    check("rdata", 64'h0, o_in_data);
  endtask
  initial
  begin
    #20us;
    num_errors++;
    report_and_stop;
  end
  initial
  begin
    repeat (5) @(negedge i_clk);
    i_sys_rst = 1'h0;
    t_read;
    t_send;
    t_gate;
    t_reset;
    report_and_stop;
  end
endmodule // bsh_gateway_tb_top
